// *** logic/aspc_serial_port.sv ***
// Serial output port and control pins of the sigma-delta converter.
// Assumes i_clk_sys is the master clock; all pins are asynchronous.
`include "aspc_consts.svh"
`default_nettype none

// Summary of operation
// - Mode low: external shift clock, MSB first.
// - Mode high: drive shift clock, quarter rate.
// - Trim selects sampled at calibration request rise.
// - Standby low enters low power state.
// - Polarity select: low unipolar, high bipolar.
// - Request high over four cycles resets, calibrates.
// - Chip select falling starts word transfer.
// - Valid flag low while word is held.
// - Valid flag high after complete word.
// - Valid flag high four cycles on load.
// - Each result is a 20-bit serial word.
// - Data changes on shift clock falling edge.
// - Early deselect finishes bit, then releases pins.
// - Chip select during load interval is ignored.
module aspc_serial_port
  import aspc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  // Static and control pins
  input  wire logic       i_mode,
  input  wire logic       i_trim_select_a,
  input  wire logic       i_trim_select_b,
  input  wire logic       i_input_polarity_select,
  input  wire logic       i_standby_n,
  input  wire logic       i_cal_req,
  // Serial port pins
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  output logic            o_sclk,
  output logic            o_sclk_oe,
  output logic            o_serial_out_data,
  output logic            o_serial_out_data_oe,
  output logic            o_word_valid_n,
  // Conversion words from the filter
  input  wire logic       i_conv_valid,
  input  wire aspc_word_t i_conv_data,
  output logic            o_conv_ready,
  // Core control
  output logic            o_low_power,
  output logic            o_bipolar,
  output aspc_cal_t       o_cal
);

  aspc_pins_t  pins_m_q;
  aspc_pins_t  pins_s_q;
  logic        sclk_prev_q;
  logic        cs_prev_q;
  logic        cal_prev_q;
  logic [2:0]  cal_cnt_q;
  aspc_cal_t   cal_q;
  aspc_state_t state_q;
  logic [2:0]  load_cnt_q;
  aspc_word_t  word_q;
  aspc_word_t  shreg_q;
  logic [4:0]  bit_cnt_q;
  logic        data_q;
  logic        data_oe_q;
  logic        abort_q;
  logic        self_q;
  logic [1:0]  div_q;
  logic        sclk_q;
  logic        sclk_oe_q;
  logic        low_power_q;
  logic        bipolar_q;
  logic        fifo_valid;
  logic        fifo_ready;
  aspc_word_t  fifo_data;
  logic        cs_fall;
  logic        cal_rise;
  logic        ext_fall;
  logic        fall_evt;
  logic        last;
  logic        finish;
  logic        start;
  logic        pop;

  // Conversion words wait here while a transfer holds the output word
  aspc_fifo #(
    .W     (`ASPC_WORD_W),
    .DEPTH (`ASPC_FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (i_clk_sys),
    .i_resetn   (i_resetn),
    .i_wr_valid (i_conv_valid),
    .o_wr_ready (o_conv_ready),
    .i_wr_data  (i_conv_data),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_ready),
    .o_rd_data  (fifo_data)
  );

  // Two-stage synchroniser for every pin
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      // Idle levels, so no false low power or select edge follows reset
      pins_m_q <= `ASPC_PINS_IDLE;
      pins_s_q <= `ASPC_PINS_IDLE;
    end
    else
    begin
      pins_m_q <= {i_mode, i_trim_select_b, i_trim_select_a, i_input_polarity_select,
                   i_standby_n, i_cal_req, i_cs_n, i_sclk};
      pins_s_q <= pins_m_q;
    end
  end

  // Previous levels for edge detection
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
      cal_prev_q  <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= pins_s_q.sclk;
      cs_prev_q   <= pins_s_q.cs_n;
      cal_prev_q  <= pins_s_q.cal_req;
    end
  end

  assign cs_fall  = cs_prev_q && !pins_s_q.cs_n;
  assign cal_rise = !cal_prev_q && pins_s_q.cal_req;
  assign ext_fall = sclk_prev_q && !pins_s_q.sclk;
  assign fall_evt = (state_q == ST_SHIFT) && (self_q ? sclk_q : ext_fall);
  assign last     = (bit_cnt_q == `ASPC_BIT_LAST);
  assign finish   = fall_evt && (last || abort_q);
  assign start      = (state_q == ST_VALID) && cs_fall && !cal_q.reset;
  assign fifo_ready = ((state_q == ST_EMPTY) || (state_q == ST_VALID)) && !start && !cal_q.reset;
  assign pop        = fifo_ready && fifo_valid;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      low_power_q <= 1'b0;
      bipolar_q   <= 1'b0;
    end
    else
    begin
      low_power_q <= !pins_s_q.standby_n;
      bipolar_q   <= pins_s_q.input_polarity_select;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cal_cnt_q <= 3'h0;
      cal_q     <= '0;
    end
    else
    begin
      cal_q.start <= 1'b0;
      if (cal_rise)
      begin
        cal_q.kind <= {pins_s_q.trim_select_b, pins_s_q.trim_select_a};
      end
      if (pins_s_q.cal_req)
      begin
        if (cal_cnt_q != `ASPC_CAL_HOLD_CYC)
        begin
          cal_cnt_q <= cal_cnt_q + 3'h1;
        end
        else
        begin
          cal_q.reset <= 1'b1;
        end
      end
      else
      begin
        cal_cnt_q <= 3'h0;
        if (cal_q.reset)
        begin
          cal_q.reset <= 1'b0;
          cal_q.start <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q    <= ST_EMPTY;
      load_cnt_q <= 3'h0;
    end
    else if (cal_q.reset)
    begin
      state_q <= ST_EMPTY;
    end
    else
    begin
      unique case (state_q)
        ST_EMPTY, ST_VALID:
        begin
          if (start)
          begin
            state_q <= ST_SHIFT;
          end
          else if (pop)
          begin
            state_q    <= ST_LOAD;
            load_cnt_q <= 3'h1;
          end
        end
        ST_LOAD:
        begin
          if (load_cnt_q == `ASPC_LOAD_CYC)
          begin
            state_q <= ST_VALID;
          end
          else
          begin
            load_cnt_q <= load_cnt_q + 3'h1;
          end
        end
        ST_SHIFT:
        begin
          if (finish)
          begin
            state_q <= last ? ST_EMPTY : ST_VALID;
          end
        end
      endcase
    end
  end

  // Output word capture
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      word_q <= '0;
    end
    else if (pop)
    begin
      word_q <= fifo_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      data_q    <= 1'b0;
      data_oe_q <= 1'b0;
      shreg_q   <= '0;
      bit_cnt_q <= 5'h00;
      abort_q   <= 1'b0;
      self_q    <= 1'b0;
    end
    else if (cal_q.reset)
    begin
      data_oe_q <= 1'b0;
      abort_q   <= 1'b0;
    end
    else if (start)
    begin
      data_q    <= word_q[`ASPC_WORD_W-1];
      shreg_q   <= {word_q[`ASPC_WORD_W-2:0], 1'b0};
      bit_cnt_q <= 5'h00;
      data_oe_q <= 1'b1;
      abort_q   <= 1'b0;
      self_q    <= pins_s_q.mode;
    end
    else if (state_q == ST_SHIFT)
    begin
      if (pins_s_q.cs_n)
      begin
        abort_q <= 1'b1;
      end
      if (finish)
      begin
        data_oe_q <= 1'b0;
      end
      else if (fall_evt)
      begin
        data_q    <= shreg_q[`ASPC_WORD_W-1];
        shreg_q   <= {shreg_q[`ASPC_WORD_W-2:0], 1'b0};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // self shift clock, one high phase in four
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_q     <= 2'h0;
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
    end
    else if (start)
    begin
      div_q     <= 2'h0;
      sclk_q    <= 1'b0;
      sclk_oe_q <= pins_s_q.mode;
    end
    else if ((state_q == ST_SHIFT) && !finish && !cal_q.reset)
    begin
      div_q  <= div_q + 2'h1;
      sclk_q <= self_q && (div_q == `ASPC_SSC_LAST);
    end
    else
    begin
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
    end
  end

  // Pin outputs
  assign o_sclk               = sclk_q;
  assign o_sclk_oe            = sclk_oe_q;
  assign o_serial_out_data    = data_q;
  assign o_serial_out_data_oe = data_oe_q;
  assign o_word_valid_n       = !((state_q == ST_VALID) || (state_q == ST_SHIFT));
  assign o_low_power          = low_power_q;
  assign o_bipolar            = bipolar_q;
  assign o_cal                = cal_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_start;
    start;
  endsequence

  sequence s_sclk_gap;
    !o_sclk [*3];
  endsequence

  load_hold_a: assert property (pop |=> o_word_valid_n [*4])
    else $error("valid flag not high during word load");
  valid_low_a: assert property (state_q == ST_VALID |-> !o_word_valid_n)
    else $error("valid flag high while word is held");
  cs_start_a: assert property (s_start |=> state_q == ST_SHIFT && o_serial_out_data_oe)
    else $error("chip select did not start transfer");
  msb_first_a: assert property (s_start |=> o_serial_out_data == $past(word_q[`ASPC_WORD_W-1]))
    else $error("first bit is not the MSB");
  cs_ignore_a: assert property (state_q == ST_LOAD && cs_fall |=> state_q != ST_SHIFT)
    else $error("chip select accepted during load");
  word_done_a: assert property (fall_evt && last && !cal_q.reset |=> o_word_valid_n && !o_serial_out_data_oe)
    else $error("valid flag not high after full word");
  abort_release_a: assert property (fall_evt && abort_q && !last |=> !o_serial_out_data_oe && !o_sclk_oe)
    else $error("pins not released after early deselect");
  ssc_duty_a: assert property (o_sclk |=> s_sclk_gap)
    else $error("self shift clock high too long");
  ssc_gate_a: assert property (state_q != ST_SHIFT |-> !o_sclk)
    else $error("self shift clock outside transfer");
  bit_edge_a: assert property ($changed(o_serial_out_data) |-> $past(fall_evt || start))
    else $error("data changed off falling edge");
  cal_reset_a: assert property (pins_s_q.cal_req && cal_cnt_q == `ASPC_CAL_HOLD_CYC |=> o_cal.reset)
    else $error("long calibration request gave no reset");
  cal_start_a: assert property (o_cal.reset && !pins_s_q.cal_req |=> o_cal.start && !o_cal.reset)
    else $error("calibration not started on request release");
  cal_type_a: assert property (cal_rise |=> o_cal.kind == $past({pins_s_q.trim_select_b, pins_s_q.trim_select_a}))
    else $error("calibration type not sampled at request rise");
  standby_a: assert property (1'b1 |=> o_low_power != $past(pins_s_q.standby_n))
    else $error("low power state does not follow standby");
  polarity_a: assert property (1'b1 |=> o_bipolar == $past(pins_s_q.input_polarity_select))
    else $error("polarity does not follow select");

endmodule // aspc_serial_port

`default_nettype wire

// *** logic/aspc_consts.svh ***
// Constants of the converter serial port and control block.
// Assumes the master clock is the block clock i_clk_sys.
`ifndef ASPC_CONSTS_SVH
`define ASPC_CONSTS_SVH

// Width of one conversion word
`define ASPC_WORD_W 20
// Index of the last bit of a word (word width minus one)
`define ASPC_BIT_LAST 5'h13
// Depth of the conversion word buffer
`define ASPC_FIFO_DEPTH 8
// Master cycles that mark a word load with the valid flag high
`define ASPC_LOAD_CYC 3'h4
// Master cycles the calibration request may stay high without a reset
`define ASPC_CAL_HOLD_CYC 3'h4
// Last phase of the divide-by-four self shift clock
`define ASPC_SSC_LAST 2'h3
// Synchroniser reset value: chip select and standby at their idle high level
`define ASPC_PINS_IDLE 8'h0A

`endif

// *** logic/aspc_pkg.sv ***
// Types shared by the converter serial port and control block.
// Assumes the constants header is on the include path.
`include "aspc_consts.svh"
`default_nettype none

package aspc_pkg;

  // Word holder state
  typedef enum logic [1:0] {ST_EMPTY, ST_LOAD, ST_VALID, ST_SHIFT} aspc_state_t;

  // One conversion word
  typedef logic [`ASPC_WORD_W-1:0] aspc_word_t;

  // Pins that arrive from outside the clock domain
  typedef struct packed {
    logic mode;
    logic trim_select_b;
    logic trim_select_a;
    logic input_polarity_select;
    logic standby_n;
    logic cal_req;
    logic cs_n;
    logic sclk;
  } aspc_pins_t;

  // Calibration control towards the converter core
  typedef struct packed {
    logic       reset;
    logic       start;
    logic [1:0] kind;
  } aspc_cal_t;

endpackage : aspc_pkg

`default_nettype wire

// *** logic/aspc_fifo.sv ***
// Word buffer with valid and ready on both sides.
// Assumes DEPTH is a power of two; both sides on one clock.
`default_nettype none

module aspc_fifo #(
  parameter int unsigned W     = 20,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Fill side
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  input  wire logic [W-1:0] i_wr_data,
  // Drain side
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready,
  output logic [W-1:0]      o_rd_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_ptr_q;
  logic [AW:0]  rd_ptr_q;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // Full when pointers differ only in the wrap bit
  assign full       = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty      = (wr_ptr_q == rd_ptr_q);
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign push       = i_wr_valid && !full;
  assign pop        = i_rd_ready && !empty;
  assign o_rd_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Storage entries
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_entry
    always_ff @(posedge i_clk)
    begin
      if (push && (wr_ptr_q[AW-1:0] == AW'(g)))
      begin
        mem_q[g] <= i_wr_data;
      end
    end
  end

  // Pointers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule // aspc_fifo

`default_nettype wire

// *** testbench/aspc_host_model.sv ***
// Host model that reads conversion words over the serial port.
// Assumes line levels are resolved by the bench; all moves on i_clk_sys.
`default_nettype none

module aspc_host_model (
  // Clock and pin levels
  input  wire logic i_clk_sys,
  input  wire logic i_mode,
  input  wire logic i_sclk_line,
  input  wire logic i_serial_out_data_line,
  // Pins driven by the host
  output logic      o_cs_n,
  output logic      o_sclk
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, shift clock parked low
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
  end

  // Drives chip select alone, without any shift clock
  task automatic select(input logic sel_n);
    o_cs_n <= sel_n;
  endtask

  // Reads nbits bits; hi and span measure the self shift clock
  task automatic read(input int nbits, output logic [19:0] word, output int hi, output int span);
    int c;
    int f;
    int got;
    logic prev;
    word = '0;
    hi = 0;
    span = 0;
    c = 0;
    f = -1;
    got = 0;
    prev = 1'b0;
    o_cs_n <= 1'b0;
    if (!i_mode)
    begin
      repeat (8) @(posedge i_clk_sys);
      for (int i = 0; i < nbits; i++)
      begin
        o_sclk <= 1'b1;
        word = {word[18:0], i_serial_out_data_line};
        if (i == nbits - 1 && nbits < 20) o_cs_n <= 1'b1;
        repeat (5) @(posedge i_clk_sys);
        o_sclk <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
      end
    end
    else
    begin
      while (got < nbits && c < 400)
      begin
        @(posedge i_clk_sys);
        c++;
        if (i_sclk_line && f >= 0) hi++;
        if (i_sclk_line && !prev)
        begin
          if (f < 0)
          begin
            f = c;
            hi = 1;
          end
          word = {word[18:0], i_serial_out_data_line};
          got++;
          span = c - f;
        end
        prev = i_sclk_line;
      end
    end
    o_cs_n <= 1'b1;
  endtask
endmodule // aspc_host_model

`default_nettype wire

// *** testbench/aspc_serial_port_tb.sv ***
// Testbench of the converter serial port: streams words in, reads them out.
// Assumes the package, FIFO, port and host model are compiled first.
`default_nettype none

module aspc_serial_port_tb
  import aspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Bench drive and design outputs
  logic       clk = 1'b0, resetn = 1'b0, mode = 1'b0, trim_a = 1'b0, trim_b = 1'b0;
  logic       pol = 1'b0, stby_n = 1'b1, cal = 1'b0, conv_valid = 1'b0, sd_last = 1'b0;
  aspc_word_t conv_data = '0;
  logic       cs_n, host_sclk, sclk_line, serial_out_data_line, o_sclk, o_sclk_oe, sdo, sdo_oe;
  logic       valid_n, conv_ready, low_power, bipolar;
  aspc_cal_t  cal_o;
  aspc_word_t w;
  int         err_total = 0, comparisons = 0, hi, span, n;

  // Master clock, 8 ns
  always #4 clk = ~clk;

  // Released data line shows the inverse of its last value; released shift clock line shows host_sclk
  always @(posedge clk) if (sdo_oe) sd_last <= sdo;
  assign serial_out_data_line = sdo_oe ? sdo : ~sd_last;
  assign sclk_line  = o_sclk_oe ? o_sclk : host_sclk;

  aspc_serial_port i_aspc_serial_port (
    .i_clk_sys(clk), .i_resetn(resetn), .i_mode(mode), .i_trim_select_a(trim_a),
    .i_trim_select_b(trim_b), .i_input_polarity_select(pol), .i_standby_n(stby_n),
    .i_cal_req(cal), .i_cs_n(cs_n), .i_sclk(sclk_line), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
    .o_serial_out_data(sdo), .o_serial_out_data_oe(sdo_oe), .o_word_valid_n(valid_n),
    .i_conv_valid(conv_valid), .i_conv_data(conv_data), .o_conv_ready(conv_ready),
    .o_low_power(low_power), .o_bipolar(bipolar), .o_cal(cal_o));

  aspc_host_model i_aspc_host_model (
    .i_clk_sys(clk), .i_mode(mode), .i_sclk_line(sclk_line), .i_serial_out_data_line(serial_out_data_line),
    .o_cs_n(cs_n), .o_sclk(host_sclk));

  // Compare and count
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Push k words base, base+1, ... holding valid until taken
  task automatic push_words(input int k, input aspc_word_t base);
    for (int i = 0; i < k; i++)
    begin
      conv_valid <= 1'b1;
      conv_data  <= base + aspc_word_t'(i);
      do @(posedge clk); while (conv_ready !== 1'b1);
    end
    conv_valid <= 1'b0;
  endtask

  // Wait for a held word, bounded
  task automatic wait_valid();
    n = 0;
    while (valid_n !== 1'b0 && n < 80)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #100us;
    err_total++;
    stop_test();
  end

  // Test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({valid_n, conv_ready, cal_o}, 6'h30);
    push_words(1, 20'hA5C3F);
    wait_valid();
    i_aspc_host_model.read(20, w, hi, span);
    check(w, 20'hA5C3F);
    repeat (4) @(posedge clk);
    check({valid_n, sdo_oe, o_sclk_oe}, 3'h4);
    $display("test external read done");
    push_words(1, 20'h12345);
    wait_valid();
    check(valid_n, 1'b0);
    push_words(1, 20'h6789A);
    n = 0;
    while (valid_n !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (valid_n === 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check(20'(n), 20'h4);
    $display("test word load done");
    i_aspc_host_model.read(5, w, hi, span);
    repeat (3) @(posedge clk);
    check(w, 20'h0000C);
    check({valid_n, sdo_oe}, 2'h0);
    $display("test early deselect done");
    mode <= 1'b1;
    repeat (4) @(posedge clk);
    i_aspc_host_model.read(20, w, hi, span);
    check(w, 20'h6789A);
    check(20'(span), 20'h4C);
    check(20'(hi), 20'h14);
    repeat (4) @(posedge clk);
    check({valid_n, o_sclk_oe, sdo_oe}, 3'h4);
    $display("test self shift clock done");
    mode <= 1'b0;
    push_words(1, 20'hF0F0F);
    wait_valid();
    fork
      i_aspc_host_model.read(20, w, hi, span);
      begin
        repeat (30) @(posedge clk);
        push_words(8, 20'h10000);
        @(posedge clk);
        check(conv_ready, 1'b0);
      end
    join
    check(w, 20'hF0F0F);
    repeat (80) @(posedge clk);
    i_aspc_host_model.read(20, w, hi, span);
    check(w, 20'h10007);
    $display("test buffer fill done");
    for (int i = 0; i < 4; i++)
    begin
      pol    <= i[0];
      stby_n <= i[1];
      repeat (4) @(posedge clk);
      check({bipolar, low_power}, {i[0], ~i[1]});
    end
    $display("test static pins done");
    push_words(1, 20'h0ABCD);
    // select falls inside the load interval
    i_aspc_host_model.select(1'b0);
    repeat (20) @(posedge clk);
    check({valid_n, sdo_oe}, 2'h0);
    i_aspc_host_model.select(1'b1);
    $display("test ignored select done");
    for (int k = 0; k < 4; k++)
    begin
      trim_a <= k[0];
      trim_b <= k[1];
      repeat (3) @(posedge clk);
      // request driven as a common strobe
      cal <= 1'b1;
      repeat (4) @(posedge clk);
      cal <= 1'b0;
      n = 0;
      repeat (8)
      begin
        @(posedge clk);
        n += int'(cal_o.start | cal_o.reset);
      end
      check(20'(n), 20'h0);
      cal <= 1'b1;
      repeat (12) @(posedge clk);
      check(cal_o.reset, 1'b1);
      cal <= 1'b0;
      n = 0;
      while (cal_o.start !== 1'b1 && n < 10)
      begin
        @(posedge clk);
        n++;
      end
      check({cal_o.start, cal_o.kind}, {1'b1, k[1:0]});
    end
    $display("test calibration done");
    stop_test();
  end
endmodule // aspc_serial_port_tb

`default_nettype wire
